//--- design/udis_defines.svh
`ifndef UDIS_DEFINES_SVH
`define UDIS_DEFINES_SVH

// Register offsets (byte addresses).
`define UDIS_ADDR_W 8
`define UDIS_OFF_STATUS 8'h18
`define UDIS_OFF_ENABLE 8'h14
`define UDIS_OFF_DMA_REASON 8'h50
`define UDIS_OFF_DMA_REASON_EN 8'h54

// Status bit positions.
`define UDIS_BIT_RESET 0
`define UDIS_BIT_SOF 1
`define UDIS_BIT_PSOF 2
`define UDIS_BIT_SUSPEND 3
`define UDIS_BIT_RESUME 4
`define UDIS_BIT_DMA 6
`define UDIS_BIT_EP_BASE 10
`define UDIS_NUM_BUS_EV 5
`define UDIS_NUM_EP 8
`define UDIS_NUM_DMA_CAUSES 16

// Reset values.
`define UDIS_STATUS_RST 32'h0000_0000
`define UDIS_ENABLE_RST 32'h0000_0000
`define UDIS_REASON_RST 16'h0000

`endif

//--- design/udis_pkg.sv
`default_nettype none
package udis_pkg;
   typedef logic [31:0] udis_word_t;
   typedef logic [15:0] udis_reason_t;
endpackage
`default_nettype wire

//--- design/udis_sync.sv
`include "udis_defines.svh"
`default_nettype none
// Two-flop synchroniser followed by a rising-edge detector on the second stage.
module udis_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk_in, // Core clock.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain.
   output logic [WIDTH-1:0] rise_out // One-cycle pulse per rising edge.
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_stage2;
   logic [WIDTH-1:0] next_stage3;

   always_comb begin
      next_stage1 = async_in;
      next_stage2 = stage1;
      next_stage3 = stage2;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         stage3 <= next_stage3;
      end
   end

   // Edge detection looks only at the second and third stages.
   assign rise_out = stage2 & ~stage3;
endmodule
`default_nettype wire

//--- design/udis_w1c_reg.sv
`include "udis_defines.svh"
`default_nettype none
// Bank of sticky flags: set by events, cleared by writing one; set wins.
module udis_w1c_reg #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic core_clk_in, // Core clock.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic [WIDTH-1:0] set_in, // Event pulses.
   input wire logic [WIDTH-1:0] clear_in, // Bits to clear.
   output logic [WIDTH-1:0] flags_out // Current flags.
);
   logic [WIDTH-1:0] flags;
   logic [WIDTH-1:0] next_flags;

   always_comb begin
      next_flags = (flags & ~clear_in) | set_in;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         flags <= RESET_VAL;
      end else begin
         flags <= next_flags;
      end
   end

   assign flags_out = flags;
endmodule
`default_nettype wire

//--- design/udis_top.sv
`include "udis_defines.svh"
`default_nettype none
// Behaviour
// - Four-byte status register at offset 18h
// - Flags latch on event until cleared
// - Interrupt while enabled status bit set
// - Separate transmit/receive flag per endpoint
// - Flags for resume, suspend, pseudo-SOF, SOF, reset
// - One DMA summary flag; cause held separately
// - Writing one clears that flag only
// - DMA flag clears after reason cleared too
module udis_top #(
   parameter int NUM_EP = `UDIS_NUM_EP,
   parameter int NUM_CAUSES = `UDIS_NUM_DMA_CAUSES
) (
   input wire logic core_clk_in, // Core clock, 100 MHz.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic [`UDIS_ADDR_W-1:0] addr_in, // Register byte address.
   input wire logic [31:0] wdata_in, // Write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   output logic [31:0] rdata_out, // Read data, one cycle after rd_in.
   input wire logic bus_reset_in, // USB bus reset seen, level from link.
   input wire logic sof_in, // Start-of-frame seen.
   input wire logic pseudo_sof_in, // Pseudo start-of-frame seen.
   input wire logic suspend_in, // Bus suspended.
   input wire logic resume_in, // Bus resumed.
   input wire logic [NUM_EP-1:0] endpoint_transmit_flag_in, // Per-endpoint transmit done.
   input wire logic [NUM_EP-1:0] endpoint_receive_flag_in, // Per-endpoint receive done.
   input wire logic [NUM_CAUSES-1:0] dma_cause_in, // DMA cause events, level.
   output logic irq_out // Interrupt request, active high.
);
   function automatic logic hit(input logic [`UDIS_ADDR_W-1:0] a,
                                input logic [`UDIS_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Every event input comes from the USB core, possibly another domain.
   localparam int TX_LANE = `UDIS_NUM_BUS_EV;
   localparam int RX_LANE = TX_LANE + NUM_EP;
   localparam int CAUSE_LANE = RX_LANE + NUM_EP;
   localparam int EVW = CAUSE_LANE + NUM_CAUSES;
   logic [EVW-1:0] ev_raw;
   logic [EVW-1:0] ev_rise;

   assign ev_raw = {dma_cause_in, endpoint_receive_flag_in, endpoint_transmit_flag_in,
                    resume_in, suspend_in, pseudo_sof_in, sof_in, bus_reset_in};

   udis_sync #(.WIDTH(EVW)) u_sync (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .async_in(ev_raw),
      .rise_out(ev_rise)
   );

   logic [NUM_EP-1:0] tx_ev;
   logic [NUM_EP-1:0] rx_ev;
   logic [NUM_CAUSES-1:0] cause_ev;
   assign tx_ev = ev_rise[TX_LANE +: NUM_EP];
   assign rx_ev = ev_rise[RX_LANE +: NUM_EP];
   assign cause_ev = ev_rise[CAUSE_LANE +: NUM_CAUSES];

   // Endpoint flags interleave receive then transmit, one pair per endpoint.
   logic [2*NUM_EP-1:0] ep_set;
   for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
      assign ep_set[2 * i] = rx_ev[i];
      assign ep_set[2 * i + 1] = tx_ev[i];
   end

   logic wr_status;
   logic wr_reason;
   assign wr_status = wr_in && hit(addr_in, `UDIS_OFF_STATUS);
   assign wr_reason = wr_in && hit(addr_in, `UDIS_OFF_DMA_REASON);

   // DMA cause flags, held separately from the summary.
   logic [NUM_CAUSES-1:0] reason;
   logic [NUM_CAUSES-1:0] reason_clr;
   assign reason_clr = wr_reason ? wdata_in[NUM_CAUSES-1:0] : '0;

   udis_w1c_reg #(.WIDTH(NUM_CAUSES), .RESET_VAL('0)) u_reason (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .set_in(cause_ev),
      .clear_in(reason_clr),
      .flags_out(reason)
   );

   udis_pkg::udis_word_t status_set;
   udis_pkg::udis_word_t status_clr;
   udis_pkg::udis_word_t status;
   logic [NUM_CAUSES-1:0] next_reason_view;

   always_comb begin
      status_set = '0;
      // The bus events sit in the lowest lanes in the same order as their status bits.
      status_set[`UDIS_BIT_RESET] = ev_rise[`UDIS_BIT_RESET];
      status_set[`UDIS_BIT_SOF] = ev_rise[`UDIS_BIT_SOF];
      status_set[`UDIS_BIT_PSOF] = ev_rise[`UDIS_BIT_PSOF];
      status_set[`UDIS_BIT_SUSPEND] = ev_rise[`UDIS_BIT_SUSPEND];
      status_set[`UDIS_BIT_RESUME] = ev_rise[`UDIS_BIT_RESUME];
      // The summary is re-raised by any new cause event.
      status_set[`UDIS_BIT_DMA] = |cause_ev;
      status_set[`UDIS_BIT_EP_BASE +: 2 * NUM_EP] = ep_set;
   end

   // Reason value once this cycle's reason write has taken effect.
   always_comb begin
      next_reason_view = (reason & ~reason_clr) | cause_ev;
   end

   always_comb begin
      status_clr = wr_status ? wdata_in : '0;
      // The summary only clears once no cause remains pending, so a clear issued
      // before the reason register is cleared leaves it set.
      if (|next_reason_view) begin
         status_clr[`UDIS_BIT_DMA] = 1'b0;
      end
   end

   udis_w1c_reg #(.WIDTH(32), .RESET_VAL(`UDIS_STATUS_RST)) u_status (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .set_in(status_set),
      .clear_in(status_clr),
      .flags_out(status)
   );

   // Enable register: plain read/write, it gates only the interrupt.
   udis_pkg::udis_word_t enable;
   udis_pkg::udis_word_t next_enable;
   udis_pkg::udis_word_t rdata;
   udis_pkg::udis_word_t next_rdata;
   logic irq;
   logic next_irq;

   always_comb begin
      next_enable = enable;
      if (wr_in && hit(addr_in, `UDIS_OFF_ENABLE)) begin
         next_enable = wdata_in;
      end
   end

   always_comb begin
      next_rdata = '0;
      if (rd_in) begin
         if (hit(addr_in, `UDIS_OFF_STATUS)) begin
            next_rdata = status;
         end else if (hit(addr_in, `UDIS_OFF_ENABLE)) begin
            next_rdata = enable;
         end else if (hit(addr_in, `UDIS_OFF_DMA_REASON)) begin
            next_rdata[NUM_CAUSES-1:0] = reason;
         end
      end
   end

   always_comb begin
      next_irq = |(status & enable);
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         enable <= `UDIS_ENABLE_RST;
         rdata <= '0;
         irq <= 1'b0;
      end else begin
         enable <= next_enable;
         rdata <= next_rdata;
         irq <= next_irq;
      end
   end

   assign rdata_out = rdata;
   assign irq_out = irq;
endmodule
`default_nettype wire

//--- test/udis_checker.sv
`default_nettype none
module udis_checker (
   input wire logic core_clk_in, // Core clock.
   input wire logic rst_in, // Synchronous reset.
   input wire logic [7:0] addr_in, // Byte address.
   input wire logic [31:0] wdata_in, // Write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   input wire logic [31:0] rdata_out, // Read data.
   input wire logic irq_out // Interrupt request.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Shadow of the enable register, rebuilt from bus writes alone.
   logic [31:0] en;
   logic [31:0] next_en;
   always_comb begin
      next_en = en;
      if (wr_in && addr_in == 8'h14)
         next_en = wdata_in;
   end
   always_ff @(posedge core_clk_in) begin
      en <= rst_in ? 32'h0 : next_en;
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data outside its slot");
   a_unmapped_read: assert property (
      rd_in && !(addr_in inside {8'h14, 8'h18, 8'h50, 8'h54}) |=> rdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_status_bits: assert property (
      rd_in && addr_in == 8'h18 |=> (rdata_out & 32'hFC00_03A0) == 32'h0)
      else $error("unused status bit set");
   a_reason_width: assert property (rd_in && addr_in == 8'h50 |=> rdata_out[31:16] == 16'h0)
      else $error("reason wider than 16 bits");
   a_enable_readback: assert property (rd_in && addr_in == 8'h14 |=> rdata_out == $past(en))
      else $error("enable readback wrong");
   a_irq_enabled: assert property (irq_out |-> $past(en) != 32'h0)
      else $error("interrupt with nothing enabled");
   a_irq_fall_cause: assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
      else $error("interrupt dropped without a write");
   a_irq_hold: assert property (irq_out && !wr_in && !$past(wr_in) |=> irq_out)
      else $error("interrupt dropped on its own");
endmodule
bind udis_top udis_checker chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
`default_nettype wire

//--- test/udis_host.sv
`default_nettype none
module udis_host (
   input wire logic clk_in, // Core clock.
   input wire logic [31:0] rdata_in, // Read data from the device.
   output logic [7:0] addr_out, // Byte address.
   output logic [31:0] wdata_out, // Write data.
   output logic wr_out, // Write strobe.
   output logic rd_out // Read strobe.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_out = 8'h00;
      wdata_out = 32'h0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // Address and data are inverted once the strobe drops, so stale values never look valid.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      @(posedge clk_in);
      d = rdata_in;
   endtask
   task automatic service(output logic [31:0] src);
      logic [31:0] st;
      logic [31:0] en;
      rd(8'h18, st);
      rd(8'h14, en);
      src = st & en;
      wr(8'h18, src);
   endtask
endmodule
`default_nettype wire

//--- test/tb_usb_device_interrupt_status.sv
`default_nettype none
module tb_usb_device_interrupt_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, got, src;
   logic [31:0] ev = 32'h0;
   udis_pkg::udis_reason_t cause = 16'h0;
   logic [7:0] ep_rx, ep_tx;
   logic wr, rd, irq;
   int error_cnt = 0;
   int n_tests = 0;
   initial forever #5 core_clk_in = ~core_clk_in;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ep_rx[i] = ev[10 + 2 * i];
         ep_tx[i] = ev[11 + 2 * i];
      end
   end
   udis_top uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .bus_reset_in(ev[0]), .sof_in(ev[1]),
      .pseudo_sof_in(ev[2]), .suspend_in(ev[3]), .resume_in(ev[4]),
      .endpoint_transmit_flag_in(ep_tx), .endpoint_receive_flag_in(ep_rx),
      .dma_cause_in(cause), .irq_out(irq));
   udis_host host (.clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
      host.rd(a, got);
      check(got, exp);
   endtask
   task automatic chk_irq(input logic exp);
      #1;
      check({31'h0, irq}, {31'h0, exp});
   endtask
   // Inputs stay high two cycles so the synchroniser cannot miss them.
   task automatic pulse(input logic [31:0] e, input logic [15:0] c);
      @(posedge core_clk_in);
      ev <= e;
      cause <= c;
      repeat (2) @(posedge core_clk_in);
      ev <= 32'h0;
      cause <= 16'h0;
      repeat (6) @(posedge core_clk_in);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge core_clk_in);
      rst_in <= 1'b0;
      expect_rd(8'h18, 32'h0);
      host.wr(8'h20, 32'hFFFF_FFFF);
      expect_rd(8'h20, 32'h0);
      $display("test reset done");
      for (int b = 0; b < 26; b++) begin
         if (b > 4 && b < 10)
            continue;
         pulse((32'h1 << b) | 32'h2, 16'h0);
         host.wr(8'h18, 32'h0);
         expect_rd(8'h18, (32'h1 << b) | 32'h2);
         host.wr(8'h18, 32'h1 << b);
         expect_rd(8'h18, b == 1 ? 32'h0 : 32'h2);
         host.wr(8'h18, 32'h2);
      end
      $display("test flags done");
      pulse(32'h10, 16'h0);
      chk_irq(1'b0);
      host.wr(8'h14, 32'h10);
      repeat (2) @(posedge core_clk_in);
      chk_irq(1'b1);
      host.service(src);
      check(src, 32'h10);
      repeat (2) @(posedge core_clk_in);
      chk_irq(1'b0);
      $display("test irq done");
      pulse(32'h0, 16'h0008);
      expect_rd(8'h50, 32'h8);
      expect_rd(8'h18, 32'h40);
      host.wr(8'h18, 32'h40);
      expect_rd(8'h18, 32'h40);
      host.wr(8'h50, 32'h8);
      host.wr(8'h18, 32'h40);
      expect_rd(8'h18, 32'h0);
      $display("test dma done");
      // A new event landing in the same cycle as its clear must keep the flag.
      pulse(32'h8, 16'h0);
      fork
         pulse(32'h8, 16'h0);
         begin
            repeat (2) @(posedge core_clk_in);
            host.wr(8'h18, 32'h8);
         end
      join
      expect_rd(8'h18, 32'h8);
      host.wr(8'h18, 32'h8);
      expect_rd(8'h18, 32'h0);
      $display("test set wins done");
      end_sim();
   end
endmodule
`default_nettype wire
